/* verilog/uri_pkg.sv */
// shared constants and carriers of the serial element register map
package uri_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFF_BUF   = 3'h0;
  localparam logic [2:0] OFF_IEN   = 3'h1;
  localparam logic [2:0] OFF_IID   = 3'h2;
  localparam logic [2:0] OFF_LCTL  = 3'h3;
  localparam logic [2:0] OFF_MCTL  = 3'h4;
  localparam logic [2:0] OFF_LSTAT = 3'h5;
  localparam logic [2:0] OFF_MSTAT = 3'h6;
  localparam logic [2:0] OFF_SCR   = 3'h7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RX_AVAIL_INT_EN   = 0;
  localparam int TX_EMPTY_INT_EN   = 1;
  localparam int LINE_STAT_INT_EN  = 2;
  localparam int MODEM_STAT_INT_EN = 3;
  localparam int DIVISOR_ACCESS    = 7;
  localparam int LS_RX_READY       = 0;
  localparam int LS_OVERRUN        = 1;
  localparam int LS_PARITY_FAIL    = 2;
  localparam int LS_FRAMING_FAIL   = 3;
  localparam int LS_BREAK_SEEN     = 4;
  localparam int LS_TX_HOLD_EMPTY  = 5;
  localparam int LS_TX_SHIFT_EMPTY = 6;
  localparam int MCTL_W            = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IEN_RST   = 8'h00;
  localparam logic [7:0] LCTL_RST  = 8'h00;
  localparam logic [4:0] MCTL_RST  = 5'h00;
  localparam logic [3:0] DELTA_RST = 4'h0;

  // ---------------------------------------------------------------
  // identification codes, bits 2:1:0
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    IID_NONE  = 3'h1,
    IID_LINE  = 3'h6,
    IID_RXD   = 3'h4,
    IID_TX_HOLDING_EMPTY  = 3'h2,
    IID_MODEM = 3'h0
  } uri_iid_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sel;
    logic       rd;
    logic       wr;
    logic [7:0] data;
  } uri_host_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_fail;
    logic       framing_fail;
    logic       break_seen;
  } uri_rx_s;

  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic dcd;
  } uri_modem_s;

endpackage

/* verilog/uri_prio.sv */
// four-level interrupt ranking and identification encoder
`timescale 1ns/1ps
module uri_prio
  import uri_pkg::*;
(
  // enabled pending sources: line, rx data, holding empty, modem
  input  wire logic     line_pend,
  input  wire logic     rxd_pend,
  input  wire logic     tx_holding_empty_pend,
  input  wire logic     modem_pend,
  // ranked result
  output uri_iid_e      iid,
  output logic          any_pend
);

  // ---------------------------------------------------------------
  // ranking
  // ---------------------------------------------------------------
  always_comb begin
    any_pend = line_pend | rxd_pend | tx_holding_empty_pend | modem_pend;
    if (line_pend) begin
      iid = IID_LINE;
    end else if (rxd_pend) begin
      iid = IID_RXD;
    end else if (tx_holding_empty_pend) begin
      iid = IID_TX_HOLDING_EMPTY;
    end else if (modem_pend) begin
      iid = IID_MODEM;
    end else begin
      iid = IID_NONE;
    end
  end

endmodule

/* verilog/uri_regs.sv */
// register map and prioritized interrupt logic of the serial element
`timescale 1ns/1ps
module uri_regs
  import uri_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // host register port
  input  wire uri_host_s   host,
  output logic [7:0]       rd_data,
  // receiver side
  input  wire uri_rx_s     rx,
  // transmitter side
  input  wire logic        tx_take,
  input  wire logic        tx_shift_empty,
  output logic [7:0]       tx_byte,
  output logic             tx_full,
  // modem lines and controls
  input  wire uri_modem_s  modem,
  output logic [MCTL_W-1:0] modem_ctrl,
  // line setup
  output logic [7:0]       line_ctrl,
  output logic [15:0]      divisor,
  // interrupt
  output logic             interrupt_out_pin
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]        rbuf_reg,  rbuf_next;
  logic [7:0]        thold_reg, thold_next;
  logic [7:0]        ien_reg,   ien_next;
  logic [7:0]        lctl_reg,  lctl_next;
  logic [MCTL_W-1:0] mctl_reg,  mctl_next;
  logic [7:0]        scr_reg,   scr_next;
  logic [7:0]        dll_reg,   dll_next;
  logic [7:0]        dlm_reg,   dlm_next;
  logic              rdy_reg,   rdy_next;
  logic [3:0]        err_reg,   err_next;
  logic              full_reg,  full_next;
  logic              tint_reg,  tint_next;
  logic [3:0]        delta_reg, delta_next;
  uri_modem_s        mprev_reg, mprev_next;
  logic [7:0]        rdd_reg,   rdd_next;
  logic              int_reg,   int_next;

  logic     divisor_access_bit;
  logic     rd_buf, wr_buf, rd_iid, rd_ls, rd_ms;
  logic     line_pend, rxd_pend, tx_holding_empty_pend, modem_pend, any_pend;
  uri_iid_e iid;
  logic [7:0] lsr_val, msr_val;

  function automatic logic hit(input logic [2:0] sel,
                               input logic [2:0] off);
    hit = (sel == off);
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign divisor_access_bit   = lctl_reg[DIVISOR_ACCESS];
  assign rd_buf = host.rd & hit(host.sel, OFF_BUF) & ~divisor_access_bit;
  assign wr_buf = host.wr & hit(host.sel, OFF_BUF) & ~divisor_access_bit;
  assign rd_iid = host.rd & hit(host.sel, OFF_IID);
  assign rd_ls  = host.rd & hit(host.sel, OFF_LSTAT);
  assign rd_ms  = host.rd & hit(host.sel, OFF_MSTAT);

  assign lsr_val = {1'b0, tx_shift_empty, ~full_reg, err_reg, rdy_reg};
  assign msr_val = {modem.dcd, modem.ri, modem.dsr, modem.cts, delta_reg};

  // ---------------------------------------------------------------
  // source gating and ranking
  // ---------------------------------------------------------------
  assign line_pend  = ien_reg[LINE_STAT_INT_EN]  & (|err_reg);
  assign rxd_pend   = ien_reg[RX_AVAIL_INT_EN]   & rdy_reg;
  assign tx_holding_empty_pend  = ien_reg[TX_EMPTY_INT_EN]   & tint_reg;
  assign modem_pend = ien_reg[MODEM_STAT_INT_EN] & (|delta_reg);

  uri_prio u_prio (
    .line_pend  (line_pend),
    .rxd_pend   (rxd_pend),
    .tx_holding_empty_pend  (tx_holding_empty_pend),
    .modem_pend (modem_pend),
    .iid        (iid),
    .any_pend   (any_pend)
  );

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  always_comb begin
    rbuf_next  = rbuf_reg;
    thold_next = thold_reg;
    ien_next   = ien_reg;
    lctl_next  = lctl_reg;
    mctl_next  = mctl_reg;
    scr_next   = scr_reg;
    dll_next   = dll_reg;
    dlm_next   = dlm_reg;
    rdy_next   = rdy_reg;
    err_next   = err_reg;
    full_next  = full_reg;
    tint_next  = tint_reg;
    delta_next = delta_reg;
    mprev_next = modem;
    rdd_next   = rdd_reg;
    // host writes
    if (host.wr) begin
      if (hit(host.sel, OFF_BUF) & divisor_access_bit) begin
        dll_next = host.data;
      end else if (hit(host.sel, OFF_BUF)) begin
        thold_next = host.data;
      end else if (hit(host.sel, OFF_IEN) & divisor_access_bit) begin
        dlm_next = host.data;
      end else if (hit(host.sel, OFF_IEN)) begin
        ien_next = {4'h0, host.data[3:0]};
      end else if (hit(host.sel, OFF_LCTL)) begin
        lctl_next = host.data;
      end else if (hit(host.sel, OFF_MCTL)) begin
        mctl_next = host.data[MCTL_W-1:0];
      end else if (hit(host.sel, OFF_SCR)) begin
        scr_next = host.data;
      end
    end
    // host read data
    if (host.rd) begin
      if (hit(host.sel, OFF_BUF)) begin
        rdd_next = divisor_access_bit ? dll_reg : rbuf_reg;
      end else if (hit(host.sel, OFF_IEN)) begin
        rdd_next = divisor_access_bit ? dlm_reg : ien_reg;
      end else if (hit(host.sel, OFF_IID)) begin
        rdd_next = {5'h00, iid};
      end else if (hit(host.sel, OFF_LCTL)) begin
        rdd_next = lctl_reg;
      end else if (hit(host.sel, OFF_MCTL)) begin
        rdd_next = {3'h0, mctl_reg};
      end else if (hit(host.sel, OFF_LSTAT)) begin
        rdd_next = lsr_val;
      end else if (hit(host.sel, OFF_MSTAT)) begin
        rdd_next = msr_val;
      end else begin
        rdd_next = scr_reg;
      end
    end
    // clears on access, set wins below
    if (rd_buf) begin
      rdy_next = 1'b0;
    end
    if (rd_ls) begin
      err_next = 4'h0;
    end
    if (rd_ms) begin
      delta_next = 4'h0;
    end
    if (wr_buf) begin
      full_next = 1'b1;
      tint_next = 1'b0;
    end else if (rd_iid & (iid == IID_TX_HOLDING_EMPTY)) begin
      tint_next = 1'b0;
    end
    // receiver events
    if (rx.valid) begin
      rbuf_next = rx.data;
      rdy_next  = 1'b1;
      err_next  = err_next | {rx.break_seen, rx.framing_fail,
                              rx.parity_fail, rdy_reg & ~rd_buf};
    end
    // transmitter takes the holding byte
    if (tx_take & full_reg) begin
      full_next = 1'b0;
      tint_next = 1'b1;
    end
    // modem line changes, ring counts only its falling edge
    delta_next = delta_next | {modem.dcd ^ mprev_reg.dcd,
                               mprev_reg.ri & ~modem.ri,
                               modem.dsr ^ mprev_reg.dsr,
                               modem.cts ^ mprev_reg.cts};
    int_next = any_pend;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rbuf_reg    <= 8'h00;
      thold_reg   <= 8'h00;
      ien_reg     <= IEN_RST;
      lctl_reg    <= LCTL_RST;
      mctl_reg    <= MCTL_RST;
      scr_reg     <= 8'h00;
      dll_reg     <= 8'h00;
      dlm_reg     <= 8'h00;
      rdy_reg     <= 1'b0;
      err_reg     <= 4'h0;
      full_reg    <= 1'b0;
      tint_reg    <= 1'b0;
      delta_reg   <= DELTA_RST;
      mprev_reg   <= '0;
      rdd_reg     <= 8'h00;
      int_reg     <= 1'b0;
    end else begin
      rbuf_reg    <= rbuf_next;
      thold_reg   <= thold_next;
      ien_reg     <= ien_next;
      lctl_reg    <= lctl_next;
      mctl_reg    <= mctl_next;
      scr_reg     <= scr_next;
      dll_reg     <= dll_next;
      dlm_reg     <= dlm_next;
      rdy_reg     <= rdy_next;
      err_reg     <= err_next;
      full_reg    <= full_next;
      tint_reg    <= tint_next;
      delta_reg   <= delta_next;
      mprev_reg   <= mprev_next;
      rdd_reg     <= rdd_next;
      int_reg     <= int_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data           = rdd_reg;
  assign tx_byte           = thold_reg;
  assign tx_full           = full_reg;
  assign modem_ctrl        = mctl_reg;
  assign line_ctrl         = lctl_reg;
  assign divisor           = {dlm_reg, dll_reg};
  assign interrupt_out_pin = int_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ien_upper_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    host.rd & hit(host.sel, OFF_IEN) & ~divisor_access_bit |=> rd_data[7:4] == 4'h0)
    else $error("enable upper bits not zero");

  a_int_all_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    ien_reg[3:0] == 4'h0 |=> !interrupt_out_pin)
    else $error("interrupt with all enables clear");

  a_int_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_out_pin == $past(line_pend | rxd_pend | tx_holding_empty_pend
                               | modem_pend))
    else $error("interrupt pin does not follow enabled sources");

  a_iid_idle_read: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_iid & !any_pend |=> rd_data == 8'h01)
    else $error("idle identification not 01");

  a_iid_line_top: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_iid & line_pend |=> rd_data == 8'h06)
    else $error("line status not ranked first");

  a_iid_rxd_next: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_iid & !line_pend & rxd_pend |=> rd_data == 8'h04)
    else $error("rx data not ranked second");

  a_rbr_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_buf & !rx.valid |=> !rdy_reg)
    else $error("buffer read did not clear ready");

  a_thr_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_buf & !tx_take |=> !tint_reg && !tx_holding_empty_pend)
    else $error("holding write did not clear empty interrupt");

  a_divisor_access_bit_route: assert property (@(posedge ref_clk) disable iff (!resetn)
    host.wr & hit(host.sel, OFF_BUF) & divisor_access_bit
      |=> dll_reg == $past(host.data) && $stable(thold_reg))
    else $error("divisor access not routed");

  a_scratch_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
    host.wr & hit(host.sel, OFF_SCR) ##1 !(host.wr & hit(host.sel, OFF_SCR))
      ##1 host.rd & hit(host.sel, OFF_SCR)
      |=> rd_data == $past(host.data, 3))
    else $error("scratch value lost");

  a_iid_tx_holding_empty_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_iid & (iid == IID_TX_HOLDING_EMPTY) & !(tx_take & full_reg)
      |=> !tint_reg)
    else $error("identification read did not clear empty interrupt");

  a_ms_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_ms & (modem == mprev_reg) |=> delta_reg == 4'h0)
    else $error("modem status read did not clear deltas");

endmodule

/* testbench/uri_host_model.sv */
// host register bus model with write and read cycles
`timescale 1ns/1ps
module uri_host_model
  import uri_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // register port
  input  wire logic [7:0] rd_data,
  output uri_host_s       host
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial begin
    host = '0;
  end

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    host.sel = sel;
    host.data = d;
    host.wr = 1'b1;
    @(posedge ref_clk);
    #2;
    host.wr = 1'b0;
    host.data = ~d;
  endtask

  task automatic rd(input logic [2:0] sel, output logic [7:0] d);
    @(posedge ref_clk);
    #2;
    host.sel = sel;
    host.rd = 1'b1;
    @(posedge ref_clk);
    #2;
    host.rd = 1'b0;
    d = rd_data;
  endtask
endmodule

/* testbench/uri_regs_tb.sv */
// self-checking bench of register map and interrupt logic
`timescale 1ns/1ps
module uri_regs_tb
  import uri_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------
  logic              ref_clk;
  logic              resetn;
  uri_host_s         host;
  logic [7:0]        rd_data;
  uri_rx_s           rx;
  logic              tx_take;
  logic              tx_shift_empty;
  logic [7:0]        tx_byte;
  logic              tx_full;
  uri_modem_s        modem;
  logic [MCTL_W-1:0] modem_ctrl;
  logic [7:0]        line_ctrl;
  logic [15:0]       divisor;
  logic              interrupt_out_pin;
  int                mismatches;
  int                checked;
  int                ien_m, err_m, p_rxd, p_tx_holding_empty, full_m, delta_m, rx_m;

  uri_regs dut (
    .ref_clk(ref_clk), .resetn(resetn), .host(host), .rd_data(rd_data),
    .rx(rx), .tx_take(tx_take), .tx_shift_empty(tx_shift_empty),
    .tx_byte(tx_byte), .tx_full(tx_full), .modem(modem),
    .modem_ctrl(modem_ctrl), .line_ctrl(line_ctrl), .divisor(divisor),
    .interrupt_out_pin(interrupt_out_pin)
  );

  uri_host_model host_m (
    .ref_clk(ref_clk), .rd_data(rd_data), .host(host)
  );

  // ---------------------------------------------------------------
  // model and check helpers
  // ---------------------------------------------------------------
  function automatic int exp_iid();
    if (err_m != 0 && ien_m[2]) return 6;
    if (p_rxd != 0 && ien_m[0]) return 4;
    if (p_tx_holding_empty != 0 && ien_m[1]) return 2;
    if (delta_m != 0 && ien_m[3]) return 0;
    return 1;
  endfunction

  task automatic summarize();
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd_chk(input logic [2:0] s, input logic [7:0] e,
                        input string n);
    logic [7:0] v;
    host_m.rd(s, v);
    chk(n, {8'h00, e}, {8'h00, v});
  endtask

  task automatic set_ien(input logic [7:0] v);
    host_m.wr(OFF_IEN, v);
    ien_m = v & 8'h0f;
  endtask

  task automatic chk_irq();
    int e;
    repeat (3) @(posedge ref_clk);
    #2;
    e = exp_iid();
    chk("irq_pin", 16'(e != 1), {15'h0, interrupt_out_pin});
    rd_chk(OFF_IID, 8'(e), "iid");
    if (e == 2) p_tx_holding_empty = 0;
  endtask

  task automatic send_rx(input logic [7:0] d, input logic [1:0] f);
    @(posedge ref_clk);
    #2;
    rx = {1'b1, d, f[0], f[1], 1'b0};
    @(posedge ref_clk);
    #2;
    rx = {1'b0, ~d, 3'h0};
    if (p_rxd != 0) err_m |= 2;
    err_m |= (int'(f[0]) << 2) | (int'(f[1]) << 3);
    p_rxd = 1;
    rx_m = d;
  endtask

  task automatic make_all(input logic f);
    logic [7:0] t;
    t = 8'($urandom);
    host_m.wr(OFF_BUF, t);
    full_m = 1;
    p_tx_holding_empty = 0;
    chk("tx_byte", {8'h00, t}, {8'h00, tx_byte});
    @(posedge ref_clk);
    #2;
    tx_take = 1'b1;
    modem = ~modem;
    @(posedge ref_clk);
    #2;
    tx_take = 1'b0;
    full_m = 0;
    p_tx_holding_empty = 1;
    delta_m |= modem.ri ? 11 : 15;
    send_rx(8'($urandom), {f, ~f});
  endtask

  task automatic clear_all();
    rd_chk(OFF_LSTAT, 8'(p_rxd | err_m | (full_m ? 0 : 32) | 64),
           "lstat");
    err_m = 0;
    rd_chk(OFF_BUF, 8'(rx_m), "rx_buf");
    p_rxd = 0;
    rd_chk(OFF_MSTAT, {modem.dcd, modem.ri, modem.dsr, modem.cts,
                       4'(delta_m)}, "mstat");
    delta_m = 0;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  initial begin
    int i;
    logic [7:0] v, w;
    mismatches = 0;
    checked = 0;
    {ien_m, err_m, p_rxd, p_tx_holding_empty, full_m, delta_m, rx_m} = '0;
    resetn = 1'b0;
    rx = '0;
    tx_take = 1'b0;
    tx_shift_empty = 1'b1;
    modem = '0;
    void'($urandom(32'h202e));
    repeat (4) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    rd_chk(OFF_IID, 8'h01, "iid_reset");
    rd_chk(OFF_IEN, 8'h00, "ien_reset");
    rd_chk(OFF_LSTAT, 8'h60, "lstat_reset");
    rd_chk(OFF_MSTAT, 8'h00, "mstat_reset");
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      host_m.wr(OFF_SCR, v);
      rd_chk(OFF_SCR, v, "scratch");
      host_m.wr(OFF_MCTL, v);
      rd_chk(OFF_MCTL, v & 8'h1f, "mctl");
      chk("modem_ctrl", {11'h000, v[4:0]}, {11'h000, modem_ctrl});
      host_m.wr(OFF_IEN, v | 8'hf0);
      rd_chk(OFF_IEN, v & 8'h0f, "ien_mask");
    end
    set_ien(8'h00);
    host_m.wr(OFF_LCTL, 8'h83);
    chk("line_ctrl", 16'h0083, {8'h00, line_ctrl});
    v = 8'($urandom);
    w = 8'($urandom);
    host_m.wr(OFF_BUF, v);
    host_m.wr(OFF_IEN, w);
    chk("divisor", {w, v}, divisor);
    chk("tx_full", 16'h0000, {15'h0, tx_full});
    rd_chk(OFF_BUF, v, "div_low");
    rd_chk(OFF_IEN, w, "div_high");
    host_m.wr(OFF_LCTL, 8'h03);
    rd_chk(OFF_IEN, 8'h00, "ien_back");
    send_rx(8'($urandom), 2'b00);
    chk_irq();
    set_ien(8'h01);
    chk_irq();
    rd_chk(OFF_BUF, 8'(rx_m), "rx_buf");
    p_rxd = 0;
    chk_irq();
    for (i = 0; i < 4; i++) begin
      make_all(i[0]);
      set_ien(8'(1 << i));
      chk_irq();
      clear_all();
      chk_irq();
    end
    set_ien(8'h0f);
    make_all(1'b1);
    chk_irq();
    rd_chk(OFF_LSTAT, 8'(p_rxd | err_m | 96), "lstat_all");
    err_m = 0;
    chk_irq();
    rd_chk(OFF_BUF, 8'(rx_m), "rx_buf");
    p_rxd = 0;
    chk_irq();
    chk_irq();
    clear_all();
    chk_irq();
    tx_shift_empty = 1'b0;
    rd_chk(OFF_LSTAT, 8'h20, "lstat_shift");
    summarize();
  end
endmodule
